// file: design/bws_top.sv
module bws_top
    import bws_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_arst_n,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [DATA_W-1:0] o_rdata,
    input  wire logic              i_brk_req,
    input  wire logic              i_brk_exit,
    input  wire logic              i_wait_exec,
    input  wire logic              i_stop_exec,
    input  wire logic              i_wake_req,
    input  wire logic              i_rst_pin,
    input  wire logic              i_rst_wdog,
    input  wire logic              i_rst_illegal_opcode_flag,
    input  wire logic              i_rst_illegal_address_flag,
    input  wire logic              i_rst_mon,
    input  wire logic              i_rst_lvi,
    output logic                   o_swi_vec_force,
    output logic                   o_break_mode,
    output logic                   o_flag_clr_allow,
    output logic                   o_imask_clr,
    output logic                   o_cpu_clk_en,
    output logic                   o_periph_clk_en,
    output logic                   o_wdog_disable,
    output logic                   o_irq
);

    bws_bus_if bus ();

    bws_state_t        state_r;
    bws_state_t        state_nxt;
    logic [DATA_W-1:0] brk_fctl_r;
    logic [DATA_W-1:0] brk_aux_r;
    logic              wait_exit_r;
    logic              swi_r;
    logic              imask_clr_r;
    logic              cpu_clk_r;
    logic              periph_clk_r;
    logic              clr_allow_r;
    logic              wdog_dis_r;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rst_flags;
    logic [EV_N-1:0]   irq_evt;
    logic [EV_N-1:0]   irq_sts;
    logic [EV_N-1:0]   irq_msk;
    logic              brk_entry;
    logic              wait_brk_exit;
    logic              low_pwr_entry;
    logic              wake;

    assign bus.addr  = i_addr;
    assign bus.wdata = i_wdata;
    assign bus.wr    = i_wr;
    assign bus.rd    = i_rd;

    // Power and break state sequencing
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN:
            begin
                if (i_brk_req)
                begin
                    state_nxt = ST_BREAK;
                end
                else if (i_wait_exec)
                begin
                    state_nxt = ST_WAIT;
                end
                else if (i_stop_exec)
                begin
                    state_nxt = ST_STOP;
                end
            end
            ST_WAIT:
            begin
                if (i_brk_req)
                begin
                    state_nxt = ST_BREAK;
                end
                else if (i_wake_req)
                begin
                    state_nxt = ST_RUN;
                end
            end
            ST_STOP:
            begin
                if (i_brk_req)
                begin
                    state_nxt = ST_BREAK;
                end
                else if (i_wake_req)
                begin
                    state_nxt = ST_RUN;
                end
            end
            ST_BREAK:
            begin
                if (i_brk_exit)
                begin
                    state_nxt = ST_RUN;
                end
            end
            default:
            begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_r <= ST_RUN;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign brk_entry     = (state_r != ST_BREAK) && (state_nxt == ST_BREAK);
    assign wait_brk_exit = (state_r == ST_WAIT) && (state_nxt == ST_BREAK);
    assign low_pwr_entry = (state_r == ST_RUN) && (state_nxt == ST_WAIT || state_nxt == ST_STOP);
    assign wake          = (state_r == ST_WAIT || state_r == ST_STOP) && (state_nxt == ST_RUN);

    // Break flag control register
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            brk_fctl_r <= BRK_FCTL_RST;
        end
        else if (i_wr && i_addr == ADDR_BRK_FCTL)
        begin
            brk_fctl_r <= i_wdata & (8'h01 << BFC_CLR_EN);
        end
    end

    // Break auxiliary control register
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            brk_aux_r <= BRK_AUX_RST;
        end
        else if (i_wr && i_addr == ADDR_BRK_AUX)
        begin
            brk_aux_r <= i_wdata & (8'h01 << BAUX_WDOG_DIS);
        end
    end

    // Wait exit by break, held through the break routine
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            wait_exit_r <= 1'b0;
        end
        else if (wait_brk_exit)
        begin
            wait_exit_r <= 1'b1;
        end
        else if (state_r == ST_BREAK && state_nxt == ST_RUN)
        begin
            wait_exit_r <= 1'b0;
        end
    end

    // Vector force pulse on break entry
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            swi_r <= 1'b0;
        end
        else
        begin
            swi_r <= brk_entry;
        end
    end

    // Interrupt mask clear pulse on wait or stop
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            imask_clr_r <= 1'b0;
        end
        else
        begin
            imask_clr_r <= low_pwr_entry;
        end
    end

    // Clock gating
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            cpu_clk_r    <= 1'b1;
            periph_clk_r <= 1'b1;
        end
        else
        begin
            cpu_clk_r    <= (state_nxt == ST_RUN) || (state_nxt == ST_BREAK);
            periph_clk_r <= (state_nxt != ST_STOP);
        end
    end

    // Flag clear permission for other modules
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            clr_allow_r <= 1'b1;
        end
        else if (state_nxt == ST_BREAK)
        begin
            clr_allow_r <= brk_fctl_r[BFC_CLR_EN];
        end
        else
        begin
            clr_allow_r <= 1'b1;
        end
    end

    // Watchdog disable during break
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            wdog_dis_r <= 1'b0;
        end
        else
        begin
            wdog_dis_r <= brk_aux_r[BAUX_WDOG_DIS] && (state_nxt == ST_BREAK);
        end
    end

    // Reset source recording
    bws_rst_flags u_rst_flags (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .bus      (bus.slave),
        .i_src    ({i_rst_pin,
                    i_rst_wdog,
                    i_rst_illegal_opcode_flag,
                    i_rst_illegal_address_flag,
                    i_rst_mon,
                    i_rst_lvi}),
        .o_flags  (rst_flags)
    );

    // Interrupt events
    always_comb
    begin
        irq_evt = '0;
        irq_evt[EV_BRK_ENTRY] = brk_entry;
        irq_evt[EV_WAIT_BRK]  = wait_brk_exit;
        irq_evt[EV_LOW_PWR]   = low_pwr_entry;
        irq_evt[EV_WAKE]      = wake;
    end

    bws_irq u_irq (
        .i_clk    (i_clk),
        .i_arst_n (i_arst_n),
        .bus      (bus.slave),
        .i_evt    (irq_evt),
        .o_sts    (irq_sts),
        .o_msk    (irq_msk),
        .o_irq    (o_irq)
    );

    // Read data, one cycle after the strobe
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rdata_r <= '0;
        end
        else if (i_rd)
        begin
            if (i_addr == ADDR_RST_SRC)
            begin
                rdata_r <= rst_flags;
            end
            else if (i_addr == ADDR_BRK_FCTL)
            begin
                rdata_r <= brk_fctl_r;
            end
            else if (i_addr == ADDR_BRK_AUX)
            begin
                rdata_r <= brk_aux_r;
            end
            else if (i_addr == ADDR_BRK_WSTS)
            begin
                rdata_r <= {6'h00, wait_exit_r, 1'b0};
            end
            else if (i_addr == ADDR_IRQ_STS)
            begin
                rdata_r <= {4'h0, irq_sts};
            end
            else if (i_addr == ADDR_IRQ_MSK)
            begin
                rdata_r <= {4'h0, irq_msk};
            end
            else
            begin
                rdata_r <= '0;
            end
        end
        else
        begin
            rdata_r <= '0;
        end
    end

    assign o_rdata          = rdata_r;
    assign o_swi_vec_force  = swi_r;
    assign o_break_mode     = (state_r == ST_BREAK);
    assign o_flag_clr_allow = clr_allow_r;
    assign o_imask_clr      = imask_clr_r;
    assign o_cpu_clk_en     = cpu_clk_r;
    assign o_periph_clk_en  = periph_clk_r;
    assign o_wdog_disable   = wdog_dis_r;

endmodule

// file: design/bws_pkg.sv
package bws_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Register map
    localparam logic [3:0] ADDR_RST_SRC  = 4'h0;
    localparam logic [3:0] ADDR_BRK_FCTL = 4'h1;
    localparam logic [3:0] ADDR_BRK_AUX  = 4'h2;
    localparam logic [3:0] ADDR_BRK_WSTS = 4'h3;
    localparam logic [3:0] ADDR_IRQ_STS  = 4'h4;
    localparam logic [3:0] ADDR_IRQ_MSK  = 4'h5;

    // Reset source flag positions
    localparam int RSF_POR  = 7;
    localparam int RSF_PIN  = 6;
    localparam int RSF_WDOG = 5;
    localparam int RSF_ILLEGAL_OPCODE_FLAG = 4;
    localparam int RSF_ILLEGAL_ADDRESS_FLAG = 3;
    localparam int RSF_MON  = 2;
    localparam int RSF_LVI  = 1;
    localparam int RSF_NSRC = 6;

    // Control and status bit positions
    localparam int BFC_CLR_EN   = 7;
    localparam int BAUX_WDOG_DIS = 0;
    localparam int BWS_WAIT_EXIT = 1;

    // Interrupt event bit positions
    localparam int EV_BRK_ENTRY = 0;
    localparam int EV_WAIT_BRK  = 1;
    localparam int EV_LOW_PWR   = 2;
    localparam int EV_WAKE      = 3;
    localparam int EV_N         = 4;

    // Reset values
    localparam logic [7:0] RST_SRC_POR_VAL = 8'h80;
    localparam logic [7:0] BRK_FCTL_RST    = 8'h00;
    localparam logic [7:0] BRK_AUX_RST     = 8'h00;
    localparam logic [3:0] IRQ_STS_RST     = 4'h0;
    localparam logic [3:0] IRQ_MSK_RST     = 4'h0;

    // Power states, Gray coded along run-wait-break and run-stop
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_WAIT  = 2'b01,
        ST_BREAK = 2'b11,
        ST_STOP  = 2'b10
    } bws_state_t;

endpackage

// file: design/bws_bus_if.sv
interface bws_bus_if;
    import bws_pkg::*;

    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;

    modport master (output addr, output wdata, output wr, output rd);
    modport slave  (input addr, input wdata, input wr, input rd);
endinterface

// file: design/bws_rst_flags.sv
module bws_rst_flags
    import bws_pkg::*;
(
    input  wire logic                i_clk,
    input  wire logic                i_arst_n,
    bws_bus_if.slave                 bus,
    input  wire logic [RSF_NSRC-1:0] i_src,
    output logic      [DATA_W-1:0]   o_flags
);

    logic [DATA_W-1:0] set_vec;
    logic              rd_clr;

    // Sources map onto PIN down to LOW_VOLTAGE_FLAG in order
    always_comb
    begin
        set_vec = '0;
        set_vec[RSF_PIN:RSF_LVI] = i_src;
    end

    assign rd_clr = bus.rd && (bus.addr == ADDR_RST_SRC);

    // Power-on sets POR and clears the rest
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_flags <= RST_SRC_POR_VAL;
        end
        else if (rd_clr)
        begin
            o_flags <= set_vec;
        end
        else
        begin
            o_flags <= o_flags | set_vec;
        end
    end

endmodule

// file: design/bws_irq.sv
module bws_irq
    import bws_pkg::*;
(
    input  wire logic            i_clk,
    input  wire logic            i_arst_n,
    bws_bus_if.slave             bus,
    input  wire logic [EV_N-1:0] i_evt,
    output logic      [EV_N-1:0] o_sts,
    output logic      [EV_N-1:0] o_msk,
    output logic                 o_irq
);

    logic [EV_N-1:0] w1c;

    assign w1c = (bus.wr && bus.addr == ADDR_IRQ_STS) ? bus.wdata[EV_N-1:0] : '0;

    // Sticky status, a new event wins over a clear
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_sts <= IRQ_STS_RST;
        end
        else
        begin
            o_sts <= (o_sts & ~w1c) | i_evt;
        end
    end

    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_msk <= IRQ_MSK_RST;
        end
        else if (bus.wr && bus.addr == ADDR_IRQ_MSK)
        begin
            o_msk <= bus.wdata[EV_N-1:0];
        end
    end

    assign o_irq = |(o_sts & o_msk);

endmodule

// file: tb/bws_cpu_model.sv
module bws_cpu_model
(
    input  wire logic i_clk,
    input  wire logic i_arst_n,
    input  wire logic i_break_mode,
    input  wire logic i_slow,
    output logic      o_brk_exit
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [4:0] dwell_r;

    // Break routine returns after a short or a long dwell
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            dwell_r    <= 5'h00;
            o_brk_exit <= 1'b0;
        end
        else
        begin
            dwell_r    <= (i_break_mode && !o_brk_exit) ? dwell_r + 5'h01 : 5'h00;
            o_brk_exit <= i_break_mode && !o_brk_exit && (dwell_r == (i_slow ? 5'h14 : 5'h02));
        end
    end
endmodule

// file: tb/bws_top_monitor.sv
module bws_top_monitor
    import bws_pkg::*;
(
    input wire logic              i_clk,
    input wire logic              i_arst_n,
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic              i_wr,
    input wire logic              i_rd,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic              i_brk_req,
    input wire logic              i_wait_exec,
    input wire logic              i_stop_exec,
    input wire logic              i_rst_pin,
    input wire logic              i_rst_wdog,
    input wire logic              i_rst_illegal_opcode_flag,
    input wire logic              i_rst_illegal_address_flag,
    input wire logic              i_rst_mon,
    input wire logic              i_rst_lvi,
    input wire logic              o_swi_vec_force,
    input wire logic              o_break_mode,
    input wire logic              o_flag_clr_allow,
    input wire logic              o_imask_clr,
    input wire logic              o_cpu_clk_en,
    input wire logic              o_periph_clk_en,
    input wire logic              o_wdog_disable
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [RSF_NSRC-1:0] src;
    logic                cen_r;
    logic                wdis_r;

    assign src = {i_rst_pin, i_rst_wdog, i_rst_illegal_opcode_flag, i_rst_illegal_address_flag, i_rst_mon, i_rst_lvi};

    // Shadow copies of the break control bits
    always_ff @(posedge i_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            cen_r  <= 1'b0;
            wdis_r <= 1'b0;
        end
        else
        begin
            cen_r  <= (i_wr && i_addr == ADDR_BRK_FCTL) ? i_wdata[BFC_CLR_EN] : cen_r;
            wdis_r <= (i_wr && i_addr == ADDR_BRK_AUX) ? i_wdata[BAUX_WDOG_DIS] : wdis_r;
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_arst_n);

    sequence s_src_read;
        (|src) ##1 !i_rd ##1 (i_rd && i_addr == ADDR_RST_SRC);
    endsequence

    sequence s_two_reads;
        (i_rd && i_addr == ADDR_RST_SRC && !(|src)) ##1 (i_rd && i_addr == ADDR_RST_SRC);
    endsequence

    a_break_swi_entry: assert property ((i_brk_req && !o_break_mode) |=> (o_break_mode && o_swi_vec_force))
        else $error("break request did not force the vector");
    a_swi_has_cause: assert property (o_swi_vec_force |-> ($past(i_brk_req) && !$past(o_break_mode)))
        else $error("vector forced without break request");
    a_wait_clk_gate: assert property ((i_wait_exec && !i_stop_exec && !i_brk_req && !o_break_mode && o_cpu_clk_en
        && o_periph_clk_en) |=> (!o_cpu_clk_en && o_periph_clk_en && o_imask_clr))
        else $error("wait entry clocks or mask wrong");
    a_stop_mask_clr: assert property ((i_stop_exec && !i_wait_exec && !i_brk_req && !o_break_mode && o_cpu_clk_en
        && o_periph_clk_en) |=> (!o_cpu_clk_en && o_imask_clr))
        else $error("stop entry clocks or mask wrong");
    a_imask_cause: assert property (o_imask_clr |-> ($past(i_wait_exec) || $past(i_stop_exec)))
        else $error("mask clear without low power entry");
    a_clear_free: assert property (!o_break_mode |-> o_flag_clr_allow)
        else $error("flag clearing blocked outside break");
    a_break_guard: assert property ((o_break_mode && $past(o_break_mode) && !$past(i_wr))
        |-> (o_flag_clr_allow == cen_r))
        else $error("flag clear permission wrong in break");
    a_wdog_break: assert property ((o_break_mode && $past(o_break_mode) && !$past(i_wr))
        |-> (o_wdog_disable == wdis_r))
        else $error("watchdog disable wrong in break");
    a_wdog_idle: assert property (!o_break_mode |-> !o_wdog_disable)
        else $error("watchdog disabled outside break");
    a_src_flags: assert property (s_src_read |=> ((o_rdata[RSF_PIN:RSF_LVI] & $past(src, 3)) == $past(src, 3)))
        else $error("reset source flag missing");
    a_read_clear: assert property (s_two_reads |=> (o_rdata == 8'h00))
        else $error("reset source flags not cleared by read");
endmodule

bind bws_top bws_top_monitor u_mon (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_brk_req(i_brk_req), .i_wait_exec(i_wait_exec), .i_stop_exec(i_stop_exec),
    .i_rst_pin(i_rst_pin), .i_rst_wdog(i_rst_wdog), .i_rst_illegal_opcode_flag(i_rst_illegal_opcode_flag), .i_rst_illegal_address_flag(i_rst_illegal_address_flag),
    .i_rst_mon(i_rst_mon), .i_rst_lvi(i_rst_lvi), .o_swi_vec_force(o_swi_vec_force),
    .o_break_mode(o_break_mode), .o_flag_clr_allow(o_flag_clr_allow), .o_imask_clr(o_imask_clr),
    .o_cpu_clk_en(o_cpu_clk_en), .o_periph_clk_en(o_periph_clk_en), .o_wdog_disable(o_wdog_disable)
);

// file: tb/testbench.sv
module testbench
    import bws_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic       i_clk = 1'b0;
    logic       i_arst_n;
    logic       wr;
    logic       rd;
    logic       slow;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic [9:0] ev;
    logic [7:0] rdata;
    logic [7:0] st;
    logic       brk_exit;
    int         errors = 0;
    int         total_checks = 0;
    int         cycles = 0;

    always #4 i_clk = ~i_clk;

    bws_top dut (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_brk_req(ev[3]), .i_brk_exit(brk_exit), .i_wait_exec(ev[2]),
        .i_stop_exec(ev[1]), .i_wake_req(ev[0]), .i_rst_pin(ev[9]), .i_rst_wdog(ev[8]),
        .i_rst_illegal_opcode_flag(ev[7]), .i_rst_illegal_address_flag(ev[6]), .i_rst_mon(ev[5]), .i_rst_lvi(ev[4]),
        .o_swi_vec_force(st[7]), .o_break_mode(st[6]), .o_flag_clr_allow(st[5]), .o_imask_clr(st[4]),
        .o_cpu_clk_en(st[3]), .o_periph_clk_en(st[2]), .o_wdog_disable(st[1]), .o_irq(st[0])
    );

    bws_cpu_model u_cpu (
        .i_clk(i_clk), .i_arst_n(i_arst_n), .i_break_mode(st[6]), .i_slow(slow), .o_brk_exit(brk_exit)
    );

    task automatic print_verdict;
        if (errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge i_clk);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
        @(posedge i_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge i_clk);
        rd <= 1'b0;
        #1;
        chk(what, rdata, exp);
    endtask

    task automatic rd_twice(input logic [7:0] exp);
        @(posedge i_clk);
        rd <= 1'b1;
        addr <= ADDR_RST_SRC;
        @(posedge i_clk);
        #1;
        chk("flags first read", rdata, exp);
        @(posedge i_clk);
        rd <= 1'b0;
        #1;
        chk("flags second read", rdata, 8'h00);
    endtask

    // One cycle of stimulus on sources and CPU events, outputs settled on return
    task automatic pulse(input logic [9:0] v);
        @(posedge i_clk);
        ev <= v;
        @(posedge i_clk);
        ev <= 10'h000;
        #1;
    endtask

    task automatic wait_run(input logic irq_exp);
        for (int k = 0; k < 40 && st[6] !== 1'b0; k++)
        begin
            @(posedge i_clk);
            #1;
        end
        chk("break left", st, {7'h16, irq_exp});
    endtask

    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            print_verdict();
        end
    end

    initial
    begin
        i_arst_n = 1'b0;
        {wr, rd, slow, addr, wdata, ev} = '0;
        repeat (12) @(posedge i_clk);
        i_arst_n <= 1'b1;
        #1;
        chk("idle outputs", st, 8'h2C);
        rd_twice(RST_SRC_POR_VAL);
        rd_chk(ADDR_BRK_FCTL, BRK_FCTL_RST, "clear enable reset");
        rd_chk(ADDR_BRK_AUX, BRK_AUX_RST, "aux reset");
        rd_chk(ADDR_BRK_WSTS, 8'h00, "wait exit reset");
        wr_reg(4'hF, 8'hFF);
        rd_chk(4'hF, 8'h00, "unmapped");
        for (int i = 0; i < RSF_NSRC; i++)
        begin
            pulse({6'(1 << i), 4'h0});
            rd_chk(ADDR_RST_SRC, {1'b0, 6'(1 << i), 1'b0}, "single source");
        end
        pulse(10'h200);
        pulse(10'h010);
        rd_twice(8'h42);
        wr_reg(ADDR_IRQ_MSK, 8'h0F);
        pulse(10'h004);
        chk("wait entry", st, 8'h35);
        pulse(10'h008);
        chk("break from wait", st, 8'hCD);
        rd_chk(ADDR_BRK_WSTS, 8'h02, "wait exit flag");
        wait_run(1'b1);
        rd_chk(ADDR_BRK_WSTS, 8'h00, "wait exit flag after");
        rd_chk(ADDR_IRQ_STS, 8'h07, "event status");
        wr_reg(ADDR_IRQ_STS, 8'h07);
        chk("status cleared", st, 8'h2C);
        wr_reg(ADDR_IRQ_MSK, 8'h00);
        wr_reg(ADDR_BRK_FCTL, 8'h80);
        wr_reg(ADDR_BRK_AUX, 8'h01);
        slow <= 1'b1;
        pulse(10'h008);
        chk("break from run", st, 8'hEE);
        rd_chk(ADDR_BRK_WSTS, 8'h00, "no wait exit");
        wait_run(1'b0);
        rd_chk(ADDR_IRQ_STS, 8'h01, "masked event");
        wr_reg(ADDR_IRQ_MSK, 8'h0F);
        chk("unmasked irq", st, 8'h2D);
        wr_reg(ADDR_IRQ_STS, 8'h01);
        pulse(10'h002);
        chk("stop entry", st, 8'h31);
        pulse(10'h001);
        chk("wake", st, 8'h2D);
        rd_chk(ADDR_IRQ_STS, 8'h0C, "low power events");
        pulse(10'h004);
        chk("wait again", st, 8'h35);
        pulse(10'h001);
        chk("wake from wait", st, 8'h2D);
        pulse(10'h100);
        @(posedge i_clk);
        i_arst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_arst_n <= 1'b1;
        #1;
        chk("idle after reset", st, 8'h2C);
        rd_twice(RST_SRC_POR_VAL);
        print_verdict();
    end
endmodule
